// file: pkg/mds_pkg.sv
// Shared constants, carriers and state codes of the address decoder.
// Assumes one clock domain and a word-wide request port from the
// application processor side.
package mds_pkg;

  // ---------------------------------------------------------------
  // Address windows seen by the application processor
  // ---------------------------------------------------------------
  localparam logic [31:0] SRAM_BASE   = 32'h0000_0000; // Low-power SRAM
  localparam logic [31:0] SRAM_SPAN   = 32'h0005_0000; // 320 KB
  localparam logic [31:0] CH_BIG_SPAN = 32'h0003_0000; // 192 KB chunk
  localparam logic [31:0] ROM_BASE    = 32'h0030_0000; // 64 KB ROM
  localparam logic [31:0] ROM_MASK    = 32'hffff_0000;
  localparam logic [31:0] Q1D_BASE    = 32'h0800_0000; // Flash 1 direct
  localparam logic [31:0] Q2D_BASE    = 32'h0a00_0000; // Flash 2 direct
  localparam logic [31:0] QD_MASK     = 32'hfe00_0000; // 32 MB
  localparam logic [31:0] Q1I_BASE    = 32'h1200_0000; // Flash 1 indirect
  localparam logic [31:0] Q2I_BASE    = 32'h1204_0000; // Flash 2 indirect
  localparam logic [31:0] LP_BASE     = 32'h2404_0000; // Low-power bridge
  localparam logic [31:0] W256K_MASK  = 32'hfffc_0000; // 256 KB
  localparam logic [31:0] APB_BASE    = 32'h4400_0000; // Peripheral bridge
  localparam logic [31:0] APB_MASK    = 32'hfc00_0000; // 64 MB

  // ---------------------------------------------------------------
  // Forwarded targets, one select bit each
  // ---------------------------------------------------------------
  localparam int unsigned FWD_N   = 6;
  localparam int unsigned FWD_ROM = 0;
  localparam int unsigned FWD_Q1D = 1;
  localparam int unsigned FWD_Q1I = 2;
  localparam int unsigned FWD_Q2D = 3;
  localparam int unsigned FWD_Q2I = 4;
  localparam int unsigned FWD_LP  = 5;
  localparam logic [FWD_N-1:0][31:0] FWD_BASES =
    {LP_BASE, Q2I_BASE, Q2D_BASE, Q1I_BASE, Q1D_BASE, ROM_BASE};
  localparam logic [FWD_N-1:0][31:0] FWD_MASKS =
    {W256K_MASK, W256K_MASK, QD_MASK, W256K_MASK, QD_MASK, ROM_MASK};

  // ---------------------------------------------------------------
  // Peripheral selects behind the bridge; last one is the catch-all
  // ---------------------------------------------------------------
  localparam int unsigned PSEL_N     = 7;
  localparam int unsigned PSEL_OTHER = 6;
  localparam logic [PSEL_N-2:0][31:0] PER_BASES = {
    32'h4600_c000,  // Fuse block
    32'h4600_4000,  // Pad configuration
    32'h4600_0000,  // Power management unit
    32'h4706_0000,  // Quadrature decoder
    32'h4400_0100,  // Serial port, synchronous view
    32'h4400_0000}; // Serial port, asynchronous view
  localparam logic [PSEL_N-2:0][31:0] PER_MASKS = {
    32'hffff_c000, 32'hffff_c000, 32'hffff_c000,
    32'hffff_0000, 32'hffff_ff00, 32'hffff_ff00};

  // ---------------------------------------------------------------
  // Chunks: 0 = 352 KB, 1 and 2 = 64 KB, 3 = 192 KB
  // ---------------------------------------------------------------
  localparam int unsigned NCH       = 4;
  localparam logic [1:0]  CH_WL     = 2'h0;
  localparam logic [1:0]  CH_SMALL0 = 2'h1;
  localparam logic [1:0]  CH_SMALL1 = 2'h2;
  localparam logic [1:0]  CH_APP    = 2'h3;
  localparam int unsigned CH_AW     = 18;     // Byte address in chunk
  localparam logic [9:0]  WL_KB     = 10'h160; // 352 KB
  localparam logic [9:0]  SMALL_KB  = 10'h040; // 64 KB
  localparam logic [9:0]  APP_KB    = 10'h0c0; // 192 KB
  localparam logic [1:0]  SYNC_FILL = 2'h3;    // Cycles to fill sync

  // ---------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [31:0] addr;
    logic        write;
    logic [3:0]  be;
    logic [31:0] wdata;
  } mds_req_t;

  typedef struct packed {
    logic [FWD_N-1:0] sel;
    logic [31:0]      addr;
    logic             write;
    logic [3:0]       be;
    logic [31:0]      wdata;
  } mds_fwd_t;

  typedef struct packed {
    logic [PSEL_N-1:0] sel;
    logic              enable;
    logic [31:0]       addr;
    logic              write;
    logic [31:0]       wdata;
  } mds_apb_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_SRAM  = 3'b001,
    ST_SREAD = 3'b010,
    ST_FWD   = 3'b011,
    ST_APB   = 3'b100
  } mds_state_t;

  typedef enum logic [1:0] {
    BR_IDLE   = 2'b00,
    BR_SETUP  = 2'b01,
    BR_ACCESS = 2'b10
  } mds_br_state_t;

endpackage

// file: core/mds_apb_bridge.sv
// Peripheral bridge: one unpipelined transfer at a time.
// Assumes start_i is a one-cycle pulse from the decoder on the same
// clock and that request fields stay put until done_o.
`timescale 1ns/1ps
module mds_apb_bridge (
  input  wire logic             clock_i,
  input  wire logic             srst_i,
  input  wire logic             start_i,
  input  wire logic [31:0]      addr_i,
  input  wire logic             write_i,
  input  wire logic [31:0]      wdata_i,
  output mds_pkg::mds_apb_t     apb_o,
  input  wire logic             apb_ready_i,
  input  wire logic [31:0]      apb_rdata_i,
  input  wire logic             apb_err_i,
  output logic                  done_o,
  output logic [31:0]           rdata_o,
  output logic                  err_o
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    mds_pkg::mds_br_state_t state; // Transfer phase
    mds_pkg::mds_apb_t      apb;   // Bus outputs
    logic                   done;  // Completion pulse
    logic [31:0]            rdata; // Captured read data
    logic                   err;   // Captured error
  } mds_br_st_t;

  localparam mds_br_st_t BR_RST = '0;

  mds_br_st_t q;
  mds_br_st_t d;
  logic [mds_pkg::PSEL_N-1:0] hit; // Peripheral decode

  // ---------------------------------------------------------------
  // Peripheral decode
  // ---------------------------------------------------------------
  // serial, quadrature, power management, pad and fuse bases
  for (genvar i = 0; i < mds_pkg::PSEL_N - 1; i++) begin : g_dec
    assign hit[i] = (addr_i & mds_pkg::PER_MASKS[i])
                    == mds_pkg::PER_BASES[i];
  end
  assign hit[mds_pkg::PSEL_OTHER] = ~|hit[mds_pkg::PSEL_N-2:0];

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    d      = q;
    d.done = 1'b0;
    case (q.state)
      // Idle until the decoder hands over a transfer
      mds_pkg::BR_IDLE: begin
        if (start_i) begin
          d.apb.sel    = hit;
          d.apb.enable = 1'b0;
          d.apb.addr   = addr_i;
          d.apb.write  = write_i;
          d.apb.wdata  = wdata_i;
          d.state      = mds_pkg::BR_SETUP;
        end
      end
      // Setup always lasts exactly one cycle
      mds_pkg::BR_SETUP: begin
        d.apb.enable = 1'b1;
        d.state      = mds_pkg::BR_ACCESS;
      end
      // Access holds until the peripheral is ready
      mds_pkg::BR_ACCESS: begin
        if (apb_ready_i) begin
          d.apb.sel    = '0;
          d.apb.enable = 1'b0;
          d.done       = 1'b1;
          d.rdata      = apb_rdata_i;
          d.err        = apb_err_i;
          d.state      = mds_pkg::BR_IDLE;
        end
      end
      default: d.state = mds_pkg::BR_IDLE;
    endcase
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  // outputs move on the rising edge only
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      q <= BR_RST;
    end else begin
      q <= d;
    end
  end

  assign apb_o   = q.apb;
  assign done_o  = q.done;
  assign rdata_o = q.rdata;
  assign err_o   = q.err;

endmodule

// file: core/mds_decoder.sv
// Address decoder and shared SRAM split for the application bus.
// Assumes the split straps are steady pins, the SRAM chunks answer
// one cycle after their enable, and all targets share clock_i.
`timescale 1ns/1ps
module mds_decoder (
  input  wire logic                       clock_i,
  input  wire logic                       srst_i,
  input  wire logic [1:0]                 cfg_split_i,
  input  wire logic                       req_valid_i,
  input  mds_pkg::mds_req_t               req_i,
  output logic                            req_ready_o,
  output logic                            rsp_valid_o,
  output logic                            rsp_err_o,
  output logic [31:0]                     rsp_rdata_o,
  output logic                            cfg_locked_o,
  output logic [mds_pkg::NCH-1:0]         chunk_app_clk_o,
  output logic [9:0]                      wireless_kb_o,
  output logic [9:0]                      app_kb_o,
  output logic [mds_pkg::NCH-1:0]         sram_en_o,
  output logic                            sram_we_o,
  output logic [3:0]                      sram_be_o,
  output logic [mds_pkg::CH_AW-1:0]       sram_addr_o,
  output logic [31:0]                     sram_wdata_o,
  input  wire logic [mds_pkg::NCH-1:0][31:0] sram_rdata_i,
  output logic                            fwd_valid_o,
  output mds_pkg::mds_fwd_t               fwd_o,
  input  wire logic                       fwd_ready_i,
  input  wire logic [31:0]                fwd_rdata_i,
  input  wire logic                       fwd_err_i,
  output mds_pkg::mds_apb_t               apb_o,
  input  wire logic                       apb_ready_i,
  input  wire logic [31:0]                apb_rdata_i,
  input  wire logic                       apb_err_i
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [1:0]            s1;        // Strap sync, first stage
    logic [1:0]            s2;        // Strap sync, second stage
    logic [1:0]            s3;        // Strap sync, third stage
    logic [1:0]            fill;      // Sync fill counter
    logic                  locked;    // Split frozen
    logic [mds_pkg::NCH-1:0] own_app; // Chunk owned by app side
    logic [9:0]            wl_kb;     // Wireless share in KB
    logic [9:0]            app_kb;    // Application share in KB
    mds_pkg::mds_state_t   state;     // Request sequencer
    logic                  ready;     // Request port open
    logic                  rsp_valid; // Answer pulse
    logic                  rsp_err;   // Answer is an error
    logic [31:0]           rsp_rdata; // Answer data
    logic [1:0]            chunk;     // Chunk being accessed
    logic [mds_pkg::NCH-1:0] sram_en; // Chunk enables
    logic                  sram_we;   // Chunk write
    logic [3:0]            sram_be;   // Chunk byte lanes
    logic [mds_pkg::CH_AW-1:0] sram_addr; // Byte address in chunk
    logic [31:0]           sram_wdata; // Chunk write data
    logic                  fwd_valid; // Forward request standing
    mds_pkg::mds_fwd_t     fwd;       // Forward request
    logic                  apb_start; // Bridge start pulse
  } mds_core_st_t;

  localparam mds_core_st_t CORE_RST = '0;

  mds_core_st_t q;
  mds_core_st_t d;

  logic [mds_pkg::FWD_N-1:0] fwd_hit;    // Forward window hits
  logic                      apb_hit;    // Bridge window hit
  logic                      sram_hit;   // Allocated SRAM hit
  logic [1:0]                sram_chunk; // Chunk for the hit
  logic [mds_pkg::CH_AW-1:0] sram_local; // Offset in the chunk
  logic                      br_done;    // Bridge finished
  logic [31:0]               br_rdata;   // Bridge read data
  logic                      br_err;     // Bridge error
  logic [31:0]               a;          // Request address
  logic [31:0]               slot_off;   // Offset past big chunk

  assign a = req_i.addr;

  // ---------------------------------------------------------------
  // Window decode
  // ---------------------------------------------------------------
  // ROM window; flash windows; low-power bridge window
  for (genvar i = 0; i < mds_pkg::FWD_N; i++) begin : g_fwd
    assign fwd_hit[i] = (a & mds_pkg::FWD_MASKS[i])
                        == mds_pkg::FWD_BASES[i];
  end

  assign apb_hit = (a & mds_pkg::APB_MASK) == mds_pkg::APB_BASE;

  // ---------------------------------------------------------------
  // SRAM decode: big app chunk first, then owned 64 KB chunks packed
  // ---------------------------------------------------------------
  assign slot_off = a - mds_pkg::CH_BIG_SPAN;

  always_comb begin
    sram_hit   = 1'b0;
    sram_chunk = mds_pkg::CH_APP;
    sram_local = a[mds_pkg::CH_AW-1:0];
    if (a - mds_pkg::SRAM_BASE < mds_pkg::SRAM_SPAN) begin
      if (a < mds_pkg::CH_BIG_SPAN) begin
        // 192 KB chunk serves the bottom
        sram_hit = 1'b1;
      end else begin
        sram_local = {2'b00, slot_off[15:0]};
        if (slot_off[16] == 1'b0) begin
          if (q.own_app[mds_pkg::CH_SMALL0]) begin
            sram_hit   = 1'b1;
            sram_chunk = mds_pkg::CH_SMALL0;
          end else if (q.own_app[mds_pkg::CH_SMALL1]) begin
            sram_hit   = 1'b1;
            sram_chunk = mds_pkg::CH_SMALL1;
          end
        end else if (&q.own_app[mds_pkg::CH_SMALL1:mds_pkg::CH_SMALL0])
        begin
          // second small chunk only when both owned
          sram_hit   = 1'b1;
          sram_chunk = mds_pkg::CH_SMALL1;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    d           = q;
    d.s1        = cfg_split_i;
    d.s2        = q.s1;
    d.s3        = q.s2;
    d.rsp_valid = 1'b0;
    d.rsp_err   = 1'b0;
    d.sram_en   = '0;
    d.apb_start = 1'b0;
    // Let the synchroniser fill before trusting it
    if (q.fill != mds_pkg::SYNC_FILL) begin
      d.fill = q.fill + 2'h1;
    end
    // capture the split once, never again
    if (!q.locked && q.fill == mds_pkg::SYNC_FILL && q.s2 == q.s3) begin
      d.locked = 1'b1;
      d.ready  = 1'b1;
      // fixed owners; strap bit set gives chunk away
      d.own_app[mds_pkg::CH_WL]     = 1'b0;
      d.own_app[mds_pkg::CH_SMALL0] = ~q.s3[0];
      d.own_app[mds_pkg::CH_SMALL1] = ~q.s3[1];
      d.own_app[mds_pkg::CH_APP]    = 1'b1;
      d.wl_kb  = mds_pkg::WL_KB
               + (q.s3[0] ? mds_pkg::SMALL_KB : 10'h000)
               + (q.s3[1] ? mds_pkg::SMALL_KB : 10'h000);
      d.app_kb = mds_pkg::APP_KB
               + (q.s3[0] ? 10'h000 : mds_pkg::SMALL_KB)
               + (q.s3[1] ? 10'h000 : mds_pkg::SMALL_KB);
    end
    case (q.state)
      // Take one request and route it
      mds_pkg::ST_IDLE: begin
        if (req_valid_i && q.ready) begin
          if (sram_hit) begin
            // strobe the chunk for one cycle
            d.ready      = 1'b0;
            d.chunk      = sram_chunk;
            d.sram_en[sram_chunk] = 1'b1;
            d.sram_we    = req_i.write;
            d.sram_be    = req_i.be;
            d.sram_addr  = sram_local;
            d.sram_wdata = req_i.wdata;
            d.state      = mds_pkg::ST_SRAM;
          end else if (|fwd_hit) begin
            // Forward request holds until taken
            d.ready     = 1'b0;
            d.fwd_valid = 1'b1;
            d.fwd.sel   = fwd_hit;
            d.fwd.addr  = a;
            d.fwd.write = req_i.write;
            d.fwd.be    = req_i.be;
            d.fwd.wdata = req_i.wdata;
            d.state     = mds_pkg::ST_FWD;
          end else if (apb_hit) begin
            // Bridge gets the request fields from fwd
            d.ready     = 1'b0;
            d.apb_start = 1'b1;
            d.fwd.addr  = a;
            d.fwd.write = req_i.write;
            d.fwd.wdata = req_i.wdata;
            d.state     = mds_pkg::ST_APB;
          end else begin
            d.rsp_valid = 1'b1;
            d.rsp_err   = 1'b1;
            d.rsp_rdata = '0;
          end
        end
      end
      // Chunk enable cycle; writes finish here
      mds_pkg::ST_SRAM: begin
        if (q.sram_we) begin
          d.rsp_valid = 1'b1;
          d.ready     = 1'b1;
          d.state     = mds_pkg::ST_IDLE;
        end else begin
          d.state = mds_pkg::ST_SREAD;
        end
      end
      // Read data from the chunk is captured
      mds_pkg::ST_SREAD: begin
        // data ready the cycle after enable
        d.rsp_valid = 1'b1;
        d.rsp_rdata = sram_rdata_i[q.chunk];
        d.ready     = 1'b1;
        d.state     = mds_pkg::ST_IDLE;
      end
      // Wait for the forwarded target
      mds_pkg::ST_FWD: begin
        if (fwd_ready_i) begin
          d.fwd_valid = 1'b0;
          d.fwd.sel   = '0;
          d.rsp_valid = 1'b1;
          d.rsp_err   = fwd_err_i;
          d.rsp_rdata = fwd_rdata_i;
          d.ready     = 1'b1;
          d.state     = mds_pkg::ST_IDLE;
        end
      end
      // Wait for the bridge
      mds_pkg::ST_APB: begin
        if (br_done) begin
          d.rsp_valid = 1'b1;
          d.rsp_err   = br_err;
          d.rsp_rdata = br_rdata;
          d.ready     = 1'b1;
          d.state     = mds_pkg::ST_IDLE;
        end
      end
      default: d.state = mds_pkg::ST_IDLE;
    endcase
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      q <= CORE_RST;
    end else begin
      q <= d;
    end
  end

  // ---------------------------------------------------------------
  // Peripheral bridge
  // ---------------------------------------------------------------
  // bridge sequences the transfer
  mds_apb_bridge u_bridge (
    .clock_i     (clock_i),
    .srst_i      (srst_i),
    .start_i     (q.apb_start),
    .addr_i      (q.fwd.addr),
    .write_i     (q.fwd.write),
    .wdata_i     (q.fwd.wdata),
    .apb_o       (apb_o),
    .apb_ready_i (apb_ready_i),
    .apb_rdata_i (apb_rdata_i),
    .apb_err_i   (apb_err_i),
    .done_o      (br_done),
    .rdata_o     (br_rdata),
    .err_o       (br_err)
  );

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign req_ready_o     = q.ready;
  assign rsp_valid_o     = q.rsp_valid;
  assign rsp_err_o       = q.rsp_err;
  assign rsp_rdata_o     = q.rsp_rdata;
  assign cfg_locked_o    = q.locked;
  assign chunk_app_clk_o = q.own_app;
  assign wireless_kb_o   = q.wl_kb;
  assign app_kb_o        = q.app_kb;
  assign sram_en_o       = q.sram_en;
  assign sram_we_o       = q.sram_we;
  assign sram_be_o       = q.sram_be;
  assign sram_addr_o     = q.sram_addr;
  assign sram_wdata_o    = q.sram_wdata;
  assign fwd_valid_o     = q.fwd_valid;
  assign fwd_o           = q.fwd;

endmodule

// file: testbench/mds_decoder_props.sv
// Checker for the decoder, bound to its top ports.
// Assumes one clock, reset synchronous and active high.
`timescale 1ns/1ps
module mds_decoder_props (
  input wire logic                clock_i,
  input wire logic                srst_i,
  input wire logic                req_valid_i,
  input mds_pkg::mds_req_t        req_i,
  input wire logic                req_ready_o,
  input wire logic                rsp_valid_o,
  input wire logic                rsp_err_o,
  input wire logic                cfg_locked_o,
  input wire logic [mds_pkg::NCH-1:0] chunk_app_clk_o,
  input wire logic [9:0]          wireless_kb_o,
  input wire logic [9:0]          app_kb_o,
  input wire logic [mds_pkg::NCH-1:0] sram_en_o,
  input wire logic                fwd_valid_o,
  input mds_pkg::mds_fwd_t        fwd_o,
  input mds_pkg::mds_apb_t        apb_o,
  input wire logic                apb_ready_i
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (srst_i);
  wire take = req_valid_i && req_ready_o; // Request taken
  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  unmap_err_a: assert property (take && req_i.addr[31:28] == 4'h3
    |=> rsp_valid_o && rsp_err_o && req_ready_o) else $error("no error");
  sram_read_a: assert property (take && !req_i.write
    && req_i.addr < 32'h0003_0000 |=> sram_en_o == 4'h8 && !req_ready_o
    ##1 sram_en_o == 4'h0 ##1 rsp_valid_o && !rsp_err_o)
    else $error("sram read timing");
  fixed_own_a: assert property (cfg_locked_o
    |-> chunk_app_clk_o[3] && !chunk_app_clk_o[0]) else $error("owner");
  split_sum_a: assert property (cfg_locked_o |->
    wireless_kb_o + app_kb_o == 10'h2a0 && wireless_kb_o == 10'h160
    + {3'h0, !chunk_app_clk_o[1], 6'h0} + {3'h0, !chunk_app_clk_o[2], 6'h0})
    else $error("split sizes");
  split_hold_a: assert property (cfg_locked_o
    |=> cfg_locked_o && $stable(chunk_app_clk_o)) else $error("split moved");
  apb_phase_a: assert property ($rose(|apb_o.sel)
    |-> !apb_o.enable ##1 apb_o.enable && $stable(apb_o.sel))
    else $error("no setup phase");
  apb_hold_a: assert property (apb_o.enable && !apb_ready_i
    |=> apb_o.enable && $stable(apb_o.addr)) else $error("access moved");
  flash_sel_a: assert property (take && req_i.addr[31:25] == 7'h04
    |=> fwd_valid_o && fwd_o.sel == 6'h02) else $error("flash select");
  qdec_sel_a: assert property (take && req_i.addr[31:16] == 16'h4706
    |-> ##2 apb_o.sel == 7'h04 && !apb_o.enable) else $error("qdec select");
endmodule

// file: testbench/mds_partner.sv
// Far side: SRAM chunks, forwarded targets and peripherals.
// Assumes registered decoder outputs; targets and peripherals answer after wait_i cycles.
`timescale 1ns/1ps
module mds_partner (
  input  wire logic          clock_i,
  input  wire logic [1:0]    wait_i,
  input  wire logic [3:0]    sram_en_i,
  input  wire logic [17:0]   sram_addr_i,
  output logic [3:0][31:0]   sram_rdata_o,
  input  wire logic          fwd_valid_i,
  input  mds_pkg::mds_fwd_t  fwd_i,
  output logic               fwd_ready_o,
  output logic [31:0]        fwd_rdata_o,
  input  mds_pkg::mds_apb_t  apb_i,
  output logic               apb_ready_o,
  output logic [31:0]        apb_rdata_o
);
  logic [3:0]  en_q;  // Chunk read in flight
  logic [17:0] ad_q;  // Offset of that read
  logic [1:0]  cnt_q; // Wait cycles spent
  wire busy = fwd_valid_i || apb_i.enable; // Target engaged
  // chunk answers one cycle after enable
  always_ff @(posedge clock_i) begin
    en_q <= sram_en_i;
    ad_q <= sram_addr_i;
  end
  // Stale data is inverted so it never passes as valid
  always_comb begin
    for (int k = 0; k < 4; k++) begin
      sram_rdata_o[k] = {8'(k), 6'h0, ad_q} ^ {32{!en_q[k]}};
    end
  end
  // wait states counted on rising edges only
  always_ff @(posedge clock_i) begin
    cnt_q <= (busy && cnt_q != wait_i) ? cnt_q + 2'h1 : 2'h0;
  end
  assign fwd_ready_o = fwd_valid_i && cnt_q == wait_i;
  assign apb_ready_o = apb_i.enable && cnt_q == wait_i;
  assign fwd_rdata_o = fwd_i.addr ^ (fwd_ready_o ? 32'h5a5a_5a5a : '1);
  assign apb_rdata_o = apb_i.addr ^ (apb_ready_o ? 32'ha5a5_a5a5 : '1);
endmodule

// file: testbench/test_mds_decoder.sv
// Self-checking bench for the decoder and SRAM split.
// Assumes package, design, checker and partner compiled first.
`timescale 1ns/1ps
module test_mds_decoder;
  logic              clock_i, srst_i, req_valid_i, req_ready_o;
  logic              rsp_valid_o, rsp_err_o, cfg_locked_o, sram_we_o;
  logic              fwd_valid_o, fwd_ready_i, fwd_err_i;
  logic              apb_ready_i, apb_err_i;
  logic [1:0]        cfg_split_i, wait_q;
  logic [3:0]        chunk_app_clk_o, sram_en_o, sram_be_o;
  logic [9:0]        wireless_kb_o, app_kb_o;
  logic [17:0]       sram_addr_o;
  logic [31:0]       rsp_rdata_o, sram_wdata_o, fwd_rdata_i, apb_rdata_i;
  logic [3:0][31:0]  sram_rdata_i;
  logic [6:0]        seen_sel; // Last target select
  mds_pkg::mds_req_t req_i;
  mds_pkg::mds_fwd_t fwd_o;
  mds_pkg::mds_apb_t apb_o;
  int                num_errors, n_checks;

  mds_decoder dut_u (.*);
  mds_partner far_u (.clock_i(clock_i), .wait_i(wait_q),
    .sram_en_i(sram_en_o), .sram_addr_i(sram_addr_o),
    .sram_rdata_o(sram_rdata_i), .fwd_valid_i(fwd_valid_o),
    .fwd_i(fwd_o), .fwd_ready_o(fwd_ready_i), .fwd_rdata_o(fwd_rdata_i),
    .apb_i(apb_o), .apb_ready_o(apb_ready_i), .apb_rdata_o(apb_rdata_i));

  initial begin
    clock_i = 1'b0;
    forever #2.5 clock_i = ~clock_i;
  end
  // Remember which target the last request reached
  always @(posedge clock_i) begin
    if (req_valid_i && req_ready_o) seen_sel <= '0;
    else if (fwd_valid_o) seen_sel <= {1'b0, fwd_o.sel};
    else if (|apb_o.sel) seen_sel <= apb_o.sel;
  end

  task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic boot(logic [1:0] straps);
    srst_i = 1'b1;
    cfg_split_i = straps;
    repeat (5) @(negedge clock_i);
    srst_i = 1'b0;
    repeat (6) @(negedge clock_i);
  endtask
  // One word request; waits for ready, then for the answer
  task automatic access(logic [31:0] a, logic w, logic e, logic [31:0] d);
    int n;
    req_i = '{addr: a, write: w, be: 4'hf, wdata: ~a};
    req_valid_i = 1'b1;
    for (n = 0; n < 20 && !req_ready_o; n++) @(negedge clock_i);
    @(negedge clock_i);
    req_valid_i = 1'b0;
    for (n = 0; n < 20 && !rsp_valid_o; n++) @(negedge clock_i);
    chk("rsp_valid", {31'h0, rsp_valid_o}, 32'h1);
    chk("rsp_err", {31'h0, rsp_err_o}, {31'h0, e});
    if (!w) chk("rsp_rdata", rsp_rdata_o, d);
    @(negedge clock_i); // Valid stays low for a full cycle
  endtask

  task automatic t_split;
    logic [9:0] w;
    for (int s = 0; s < 4; s++) begin
      boot(2'(s));
      cfg_split_i = ~2'(s); // Late strap moves must be ignored
      w = 10'h160 + (s[0] ? 10'h40 : 10'h0) + (s[1] ? 10'h40 : 10'h0);
      access(32'h0000_0010, 1'b0, 1'b0, 32'h0300_0010);
      access(32'h0000_0020, 1'b1, 1'b0, 32'h0);
      chk("sram_wdata", sram_wdata_o, 32'hffff_ffdf);
      chk("sram_we_be", {27'h0, sram_we_o, sram_be_o}, 32'h1f);
      chk("sram_addr", {14'h0, sram_addr_o}, 32'h20);
      access(32'h0003_0010, 1'b0, s == 3, s == 3 ? 32'h0 :
        (s[0] ? 32'h0200_0010 : 32'h0100_0010));
      access(32'h0004_0010, 1'b0, s != 0,
        s != 0 ? 32'h0 : 32'h0200_0010);
      chk("wl_kb", {22'h0, wireless_kb_o}, {22'h0, w});
      chk("app_kb", {22'h0, app_kb_o}, {22'h0, 10'h2a0 - w});
      chk("owner", {28'h0, chunk_app_clk_o},
        {28'h0, 1'b1, ~s[1], ~s[0], 1'b0});
    end
  endtask
  task automatic t_fwd;
    logic [31:0] a [8] = '{32'h0030_0004, 32'h0800_0000, 32'h1200_0000,
      32'h0a00_0000, 32'h1204_0000, 32'h2404_0400, 32'h3000_0000,
      32'h2020_0000};
    for (int i = 0; i < 8; i++) begin
      wait_q = 2'(i); // Prompt and slow targets
      fwd_err_i = i == 5; // Target error passed through
      access(a[i], 1'b0, i > 4, i > 5 ? 32'h0 : a[i] ^ 32'h5a5a_5a5a);
      chk("fwd_sel", {25'h0, seen_sel}, i > 5 ? 32'h0 : 32'h1 << i);
    end
  endtask
  task automatic t_apb;
    logic [31:0] a [7] = '{32'h4400_0000, 32'h4400_0100, 32'h4706_0000,
      32'h4600_0000, 32'h4600_4000, 32'h4600_c000, 32'h4401_0000};
    for (int i = 0; i < 7; i++) begin
      wait_q = 2'(i);
      apb_err_i = i[0]; // Odd transfers report a peripheral error
      access(a[i], i[0], i[0], a[i] ^ 32'ha5a5_a5a5);
      chk("apb_sel", {25'h0, seen_sel}, 32'h1 << i);
    end
  endtask

  initial begin
    srst_i = 1'b1;
    req_valid_i = 1'b0;
    req_i = '0;
    cfg_split_i = '0;
    wait_q = '0;
    fwd_err_i = 1'b0;
    apb_err_i = 1'b0;
    num_errors = 0;
    n_checks = 0;
    @(negedge clock_i);
    t_split;
    t_fwd;
    t_apb;
    close_out;
  end
  // Watchdog: tests need well under 2000 cycles
  initial begin
    #20000;
    num_errors++;
    close_out;
  end
endmodule
bind mds_decoder mds_decoder_props chk_u (.*);
